// [core/sfg_check.sv]
`default_nettype none
module sfg_check
    import sfg_pkg::*;
(
    input  wire sfg_cfg_t cfg,
    input  wire sfg_req_t req,
    output logic          allow
);
    logic in_win;
    logic in_boot;

    always_comb
    begin
        in_win  = (req.blk >= cfg.win_start)
                  && (req.blk <= cfg.win_end);
        in_boot = cfg.boot_protect && (req.blk <= SFG_BOOT_LAST_BLK);
        allow   = 1'b0;
        if (req.op != SFG_OP_NONE)
        begin
            if (in_boot)
                allow = 1'b0;
            else if (cfg.ext_mode)
                allow = 1'b1;
            else if (!req.code)
                allow = 1'b1;
            else if (cfg.self_mode)
                allow = in_win;
            else
                allow = 1'b1;
        end
    end
endmodule
`default_nettype wire

// [core/sfg_guard.sv]
// The placing of the registers and register access over AHB-Lite were left to the implementer.
`default_nettype none
module sfg_guard
    import sfg_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        boot_protect,
    input  wire logic        flash_speed_mode_hi,
    input  wire logic        flash_speed_mode_lo,
    output logic             flash_we,
    output logic             flash_erase,
    output logic [7:0]       flash_blk,
    output logic             flash_code,
    output logic             full_speed_mode,
    output logic [7:0]       max_clk_mhz
);
    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed
    {
        logic                 ext_mode;
        logic                 self_mode;
        logic [SFG_BLK_W-1:0] win_start;
        logic [SFG_BLK_W-1:0] win_end;
        logic                 wr_pend;
        logic [11:0]          addr;
        sfg_res_t             result;
        logic [15:0]          ok_cnt;
        logic [15:0]          fail_cnt;
        logic                 we;
        logic                 erase;
        logic [SFG_BLK_W-1:0] blk;
        logic                 code;
        logic                 full_speed;
        logic [7:0]           max_mhz;
        logic [31:0]          rdata;
    } sfg_state_t;

    sfg_state_t st_reg;
    sfg_state_t st_next;
    sfg_cfg_t   cfg;
    sfg_req_t   req;
    logic       allow;
    logic       fs_ok;
    logic       addr_ph;

    assign fs_ok = flash_speed_mode_hi & flash_speed_mode_lo;

    always_comb
    begin
        cfg.ext_mode     = st_reg.ext_mode;
        cfg.self_mode    = st_reg.self_mode;
        cfg.win_start    = st_reg.win_start;
        cfg.win_end      = st_reg.win_end;
        cfg.boot_protect = boot_protect;
        req.blk  = hwdata[SFG_REQ_BLK_LSB +: SFG_BLK_W];
        req.code = hwdata[SFG_REQ_CODE_BIT];
        req.op   = sfg_op_t'(hwdata[SFG_REQ_OP_LSB +: $bits(sfg_op_t)]);
    end

    sfg_check u_check
    (
        .cfg   (cfg),
        .req   (req),
        .allow (allow)
    );

    assign addr_ph = hsel & hready & htrans[1];

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb
    begin
        st_next       = st_reg;
        st_next.we    = 1'b0;
        st_next.erase = 1'b0;
        st_next.wr_pend = 1'b0;
        // straps go through a flop so the speed outputs are registered
        st_next.full_speed = fs_ok;
        st_next.max_mhz    = fs_ok ? SFG_FULL_MAX_MHZ : SFG_WIDE_MAX_MHZ;
        if (st_reg.wr_pend)
        begin
            case (st_reg.addr)
                SFG_CTRL_OFS:
                begin
                    st_next.ext_mode  = hwdata[SFG_CTRL_EXT_BIT];
                    st_next.self_mode = hwdata[SFG_CTRL_SELF_BIT];
                end
                SFG_WINDOW_OFS:
                begin
                    if (st_reg.ext_mode && !st_reg.self_mode)
                    begin
                        st_next.win_start =
                            hwdata[SFG_WIN_START_LSB +: SFG_BLK_W];
                        st_next.win_end   =
                            hwdata[SFG_WIN_END_LSB +: SFG_BLK_W];
                    end
                end
                SFG_REQ_OFS:
                begin
                    if (req.op == SFG_OP_WRITE || req.op == SFG_OP_ERASE)
                    begin
                        if (allow)
                        begin
                            st_next.we     = (req.op == SFG_OP_WRITE);
                            st_next.erase  = (req.op == SFG_OP_ERASE);
                            st_next.blk    = req.blk;
                            st_next.code   = req.code;
                            st_next.result = SFG_RES_OK;
                            st_next.ok_cnt = st_reg.ok_cnt + 16'h0001;
                        end
                        else
                        begin
                            st_next.result   = SFG_RES_FAIL;
                            st_next.fail_cnt = st_reg.fail_cnt + 16'h0001;
                        end
                    end
                end
                default:
                begin
                end
            endcase
        end
        if (addr_ph)
        begin
            st_next.wr_pend = hwrite;
            st_next.addr    = haddr[11:0];
            case (haddr[11:0])
                SFG_CTRL_OFS:
                    st_next.rdata = {30'h0000_0000, st_reg.self_mode,
                                     st_reg.ext_mode};
                SFG_WINDOW_OFS:
                    st_next.rdata = {16'h0000, st_reg.win_end,
                                     st_reg.win_start};
                SFG_STAT_OFS:
                    st_next.rdata = {st_reg.fail_cnt[13:0],
                                     st_reg.ok_cnt[15:0], st_reg.result};
                SFG_CLK_OFS:
                    st_next.rdata = {23'h00_0000, st_reg.full_speed,
                                     st_reg.max_mhz};
                default:
                    st_next.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg           <= '0;
            st_reg.win_start <= SFG_WIN_START_RST;
            st_reg.win_end   <= SFG_WIN_END_RST;
            st_reg.max_mhz   <= SFG_WIDE_MAX_MHZ;
        end
        else
            st_reg <= st_next;
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign hrdata          = st_reg.rdata;
    assign hreadyout       = 1'b1;
    assign hresp           = 1'b0;
    assign flash_we        = st_reg.we;
    assign flash_erase     = st_reg.erase;
    assign flash_blk       = st_reg.blk;
    assign flash_code      = st_reg.code;
    assign full_speed_mode = st_reg.full_speed;
    assign max_clk_mhz     = st_reg.max_mhz;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    outside_blocked_a: assert property (
        (flash_we || flash_erase) && flash_code && !$past(st_reg.ext_mode)
        && $past(st_reg.self_mode) |->
        (flash_blk >= $past(st_reg.win_start)
         && flash_blk <= $past(st_reg.win_end)))
        else $error("access outside window");
    window_locked_a: assert property (
        !$past(st_reg.ext_mode) || $past(st_reg.self_mode) |->
        $stable(st_reg.win_start) && $stable(st_reg.win_end))
        else $error("window changed outside external mode");
    boot_wins_a: assert property (
        (flash_we || flash_erase) |->
        !($past(boot_protect) && flash_blk <= SFG_BOOT_LAST_BLK))
        else $error("boot cluster rewritten");
    speed_cap_a: assert property (
        $past(rst_n) |->
        full_speed_mode == ($past(flash_speed_mode_hi)
                            && $past(flash_speed_mode_lo))
        && max_clk_mhz == (($past(flash_speed_mode_hi)
                             && $past(flash_speed_mode_lo))
                            ? SFG_FULL_MAX_MHZ : SFG_WIDE_MAX_MHZ))
        else $error("clock ceiling wrong");
    fail_noop_a: assert property (
        st_reg.fail_cnt != $past(st_reg.fail_cnt) |->
        !flash_we && !flash_erase && st_reg.result == SFG_RES_FAIL)
        else $error("rejected request reached flash");
    one_op_a: assert property (
        !(flash_we && flash_erase))
        else $error("write and erase together");

    ok_cov: cover property (flash_we && st_reg.self_mode);
    fail_cov: cover property (st_reg.result == SFG_RES_FAIL);
    win_cov: cover property ($changed(st_reg.win_end));
endmodule
`default_nettype wire

// [core/sfg_pkg.sv]
`default_nettype none
package sfg_pkg;
    // ****************************************************************
    // register map (byte addresses)
    // ****************************************************************
    localparam logic [11:0] SFG_CTRL_OFS   = 12'h000;
    localparam logic [11:0] SFG_WINDOW_OFS = 12'h004;
    localparam logic [11:0] SFG_REQ_OFS    = 12'h008;
    localparam logic [11:0] SFG_STAT_OFS   = 12'h00C;
    localparam logic [11:0] SFG_CLK_OFS    = 12'h010;

    // ctrl fields
    localparam int SFG_CTRL_EXT_BIT  = 0;
    localparam int SFG_CTRL_SELF_BIT = 1;
    // window fields
    localparam int SFG_WIN_START_LSB = 0;
    localparam int SFG_WIN_END_LSB   = 8;
    // request fields: block in [7:0], code flag bit 8, op in [17:16]
    localparam int SFG_REQ_BLK_LSB   = 0;
    localparam int SFG_REQ_CODE_BIT  = 8;
    localparam int SFG_REQ_OP_LSB    = 16;

    localparam int SFG_BLK_W = 8;

    localparam logic [7:0] SFG_WIN_START_RST = 8'h00;
    localparam logic [7:0] SFG_WIN_END_RST   = 8'hFF;
    localparam logic [7:0] SFG_BOOT_LAST_BLK = 8'h03;

    // writing clock ceilings in MHz
    localparam logic [7:0] SFG_FULL_MAX_MHZ = 8'h18;
    localparam logic [7:0] SFG_WIDE_MAX_MHZ = 8'h08;

    typedef enum logic [1:0]
    {
        SFG_OP_NONE  = 2'b00,
        SFG_OP_WRITE = 2'b01,
        SFG_OP_ERASE = 2'b10
    } sfg_op_t;

    typedef enum logic [1:0]
    {
        SFG_RES_IDLE = 2'b00,
        SFG_RES_OK   = 2'b01,
        SFG_RES_FAIL = 2'b10
    } sfg_res_t;

    typedef struct packed
    {
        sfg_op_t             op;
        logic                code;
        logic [SFG_BLK_W-1:0] blk;
    } sfg_req_t;

    typedef struct packed
    {
        logic                 ext_mode;
        logic                 self_mode;
        logic [SFG_BLK_W-1:0] win_start;
        logic [SFG_BLK_W-1:0] win_end;
        logic                 boot_protect;
    } sfg_cfg_t;
endpackage
`default_nettype wire

// [verif/sfg_guard_bench.sv]
`default_nettype none
module sfg_guard_bench
    import sfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst_n, hsel, hwrite, hresp, hreadyout;
    logic        bp, mhi, mlo, f_we, f_er, f_code, full;
    logic [1:0]  htrans, last;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, rd, lfsr, exp_stat;
    logic [7:0]  f_blk, mhz, ws, we_, exp_mhz, voltage_mode_argument;
    logic        ext, slf;
    logic [10:0] expq[$];
    logic [10:0] pulse_seen;
    sfg_op_t     rop;
    // worst-case oscillator settling, 80 us at 40 ns
    localparam int OSC_WAIT_CYC = 2000;
    int          failures, check_count, ok_n, fail_n;

    sfg_guard u_sfg_guard (.clk(clk), .rst_n(rst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .boot_protect(bp),
        .flash_speed_mode_hi(mhi), .flash_speed_mode_lo(mlo),
        .flash_we(f_we), .flash_erase(f_er), .flash_blk(f_blk),
        .flash_code(f_code), .full_speed_mode(full), .max_clk_mhz(mhz));

    assign pulse_seen = {f_er, f_we, f_code, f_blk};

    always #20 clk = ~clk;

    // ****************************************
    // checking and bus helpers
    // ****************************************
    task automatic test_done();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
        check_count++;
        if (s !== e)
        begin
            failures++;
            $display("BAD %s exp %h got %h", nm, e, s);
        end
    endtask

    // bounded: a stuck slave ends the run instead of hanging it
    task automatic wait_rdy();
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1)
        begin
            failures++;
            test_done();
        end
    endtask

    task automatic bus(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {20'h0_0000, a};
        hwrite <= w;
        hsize  <= 3'h2;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask

    task automatic rdchk(string nm, logic [11:0] a, logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask

    task automatic ctrl(logic e, logic s);
        ext = e;
        slf = s;
        bus(1'b1, SFG_CTRL_OFS, {30'h0, s, e});
    endtask

    // bounds only move in external mode without self mode
    task automatic win(logic [7:0] s, logic [7:0] e);
        if (ext && !slf)
        begin
            ws  = s;
            we_ = e;
        end
        bus(1'b1, SFG_WINDOW_OFS, {16'h0, e, s});
    endtask

    task automatic req(sfg_op_t op, logic c, logic [7:0] b);
        logic ok;
        // boot cluster wins for every request; window only for code
        ok = !(bp && b <= SFG_BOOT_LAST_BLK)
             && (!c || !slf || ext || (b >= ws && b <= we_));
        if (ok)
        begin
            expq.push_back({op, c, b});
            ok_n++;
        end
        else
            fail_n++;
        last = ok ? SFG_RES_OK : SFG_RES_FAIL;
        bus(1'b1, SFG_REQ_OFS, {14'h0, op, 7'h0, c, b});
    endtask

    function automatic logic [31:0] nxt(logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // ****************************************
    // pulse watcher
    // ****************************************
    always @(posedge clk)
        if (rst_n && (f_we === 1'b1 || f_er === 1'b1))
        begin
            if (expq.size() == 0)
                chk("pulse", 32'h0, 32'h1);
            else
                chk("pulse", 32'(expq.pop_front()), 32'(pulse_seen));
        end

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        clk = 1'b0;
        rst_n = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        htrans = 2'h0;
        hsize = 3'h2;
        haddr = 32'h0;
        hwdata = 32'h0;
        bp = 1'b0;
        mhi = 1'b0;
        mlo = 1'b0;
        lfsr = 32'h0000_c189;
        ext = 1'b0;
        slf = 1'b0;
        ws = 8'h00;
        we_ = 8'hff;
        last = 2'h0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rdchk("window", SFG_WINDOW_OFS, 32'h0000_ff00);
        rdchk("stat", SFG_STAT_OFS, 32'h0000_0000);
        for (int i = 0; i < 4; i++)
        begin
            {mhi, mlo} <= i[1:0];
            // software asks for full speed only when both bits allow it
            voltage_mode_argument = (i == 3) ? 8'h00 : 8'h01;
            exp_mhz = (voltage_mode_argument == 8'h00) ? 8'h18 : 8'h08;
            rdchk("clkreg", SFG_CLK_OFS, {23'h0, i == 3, exp_mhz});
            chk("speed", {i == 3, exp_mhz}, {full, mhz});
        end
        ctrl(1'b1, 1'b0);
        win(8'h04, 8'h06);
        rdchk("window", SFG_WINDOW_OFS, 32'h0000_0604);
        req(SFG_OP_WRITE, 1'b1, 8'h07);
        req(SFG_OP_ERASE, 1'b1, 8'h09);
        ctrl(1'b1, 1'b1);
        rdchk("ctrl", SFG_CTRL_OFS, 32'h0000_0003);
        win(8'h00, 8'hff);
        // software side: oscillator never halted, irqs masked, no RAM use
        ctrl(1'b0, 1'b1);
        repeat (OSC_WAIT_CYC) @(posedge clk);
        win(8'h00, 8'hff);
        rdchk("window", SFG_WINDOW_OFS, 32'h0000_0604);
        for (int b = 3; b < 8; b++)
        begin
            req(SFG_OP_WRITE, 1'b1, 8'(b));
            req(SFG_OP_ERASE, 1'b1, 8'(b));
        end
        req(SFG_OP_ERASE, 1'b0, 8'h09);
        ctrl(1'b1, 1'b0);
        win(8'h00, 8'h06);
        bp <= 1'b1;
        ctrl(1'b0, 1'b1);
        req(SFG_OP_WRITE, 1'b1, 8'h02);
        req(SFG_OP_ERASE, 1'b1, 8'h03);
        req(SFG_OP_ERASE, 1'b1, 8'h04);
        bp <= 1'b0;
        win(8'h04, 8'h06);
        for (int i = 0; i < 40; i++)
        begin
            lfsr = nxt(lfsr);
            rop = lfsr[3] ? SFG_OP_ERASE : SFG_OP_WRITE;
            req(rop, lfsr[4], 8'(lfsr[2:0]) + 8'h02);
        end
        rdchk("unmapped", 12'h020, 32'h0000_0000);
        repeat (4) @(posedge clk);
        chk("pending", 32'h0, 32'(expq.size()));
        exp_stat = {fail_n[13:0], ok_n[15:0], last};
        rdchk("stat", SFG_STAT_OFS, exp_stat);
        test_done();
    end
endmodule
`default_nettype wire
